// ### include/usb_sie_defines.svh
/*
 * register offsets, field positions, reset values and timing counts
 * for the usb serial interface engine status and control block.
 * assumes a 50 mhz sys_clk and a 32-bit apb register port.
 */
`ifndef USB_SIE_DEFINES_SVH
`define USB_SIE_DEFINES_SVH

// register byte offsets
`define OFS_ERROR_FLAGS 8'h00
`define OFS_XFER_STATUS 8'h04
`define OFS_CONTROL 8'h08
`define OFS_IRQ_FLAGS 8'h0c
`define OFS_TOKEN_CMD 8'h10

// error flag register fields
`define EF_PID_BIT 0
`define EF_CRC_EOF_BIT 1
`define EF_TURN_BIT 4
`define EF_DMA_BIT 5
`define EF_RESET 8'h00

// interrupt flag register field
`define IF_XFER_DONE_BIT 3

// transfer status fields
`define ST_EP_LSB 4
`define ST_DIR_BIT 3
`define ST_ODD_BIT 2

// control register fields
`define CT_JSTATE_BIT 7
`define CT_SE0_BIT 6
`define CT_PACKET_PROCESSING_DISABLE_BIT 5
`define CT_BUSRST_BIT 4
`define CT_HOST_CAPABILITY_ENABLE_BIT 3
`define CT_RESUME_BIT 2
`define CT_PPBRST_BIT 1
`define CT_USBEN_BIT 0
`define CT_RESET 8'h00

// timing
`define CLK_PERIOD_NS 20
`define TURN_BIT_TIMES 16
`define LS_EOP_NS 1333
`define LS_EOP_CYC ((`LS_EOP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### include/usb_sie_pkg.sv
/*
 * types shared by the usb serial interface engine status block.
 * assumes nothing beyond the defines header.
 */
package usb_sie_pkg;

    // one transfer status entry
    typedef struct packed {
        logic [3:0] ep;
        logic dir;
        logic odd;
    } xfer_stat_t;

    // events and levels from the packet engine, same clock
    typedef struct packed {
        logic tok_crc_bad;
        logic pid_bad;
        logic dma_late;
        logic rx_trunc;
        logic sof_zero;
        logic link_busy;
        logic eop;
        logic await_resp;
        logic rx_start;
        logic bit_tick;
        logic setup_tok;
        logic tok_done;
        logic xfer_done;
        xfer_stat_t stat;
    } sie_evt_t;

    // controls back to the packet engine
    typedef struct packed {
        logic proc_en;
        logic tok_reject;
        logic tok_start;
        logic [7:0] tok_cmd;
        logic host_en;
        logic host_rst;
    } sie_ctl_t;

    // apb request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

endpackage

// ### src/usb_stat_fifo.sv
/*
 * small status fifo of flip-flops with registered full and empty.
 * assumes push is only given while not full, pop only while not empty.
 */
`timescale 1ns/1ps

module usb_stat_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic [WIDTH-1:0] din,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
        logic full;
        logic empty;
    } fifo_st_t;

    fifo_st_t st_r;
    fifo_st_t st_nxt;
    logic [AW:0] cnt_n;

    // pointer and count update
    always_comb begin
        st_nxt = st_r;
        cnt_n = st_r.cnt;
        if (push) begin
            st_nxt.mem[st_r.wr] = din;
            st_nxt.wr = (st_r.wr == AW'(DEPTH - 1)) ? '0 : st_r.wr + 1'b1;
            cnt_n = cnt_n + 1'b1;
        end
        if (pop) begin
            st_nxt.rd = (st_r.rd == AW'(DEPTH - 1)) ? '0 : st_r.rd + 1'b1;
            cnt_n = cnt_n - 1'b1;
        end
        st_nxt.cnt = cnt_n;
        st_nxt.full = (cnt_n == (AW+1)'(DEPTH));
        st_nxt.empty = (cnt_n == '0);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '{default: '0, empty: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign head = st_r.mem[st_r.rd];
    assign full = st_r.full;
    assign empty = st_r.empty;
endmodule

// ### src/usb_sie_status_control.sv
/*
 * usb serial interface engine status and control registers:
 * error flags, transfer status fifo, live line state, packet disable,
 * token busy, host bus reset, host enable and resume signalling.
 * assumes a packet engine on sys_clk feeding sie_evt_t, the usb line
 * pins arriving asynchronously, and an apb master on sys_clk.
 */
`timescale 1ns/1ps
`include "usb_sie_defines.svh"

module usb_sie_status_control #(
    parameter int FIFO_DEPTH = 4,
    parameter int TURN_BITS = `TURN_BIT_TIMES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire usb_sie_pkg::apb_req_t apb_req,
    output usb_sie_pkg::apb_rsp_t apb_rsp,
    input wire usb_sie_pkg::sie_evt_t sie_evt,
    output logic xfer_ready,
    output usb_sie_pkg::sie_ctl_t sie_ctl,
    input wire logic usb_dp_in,
    input wire logic usb_dm_in,
    output logic usb_dp_out,
    output logic usb_dm_out,
    output logic usb_oe_n
);
    import usb_sie_pkg::*;

    localparam int OCC_W = $clog2(FIFO_DEPTH) + 1;

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        apb_rsp_t rsp;
        sie_ctl_t ctl;
        logic [1:0] line_s1;
        logic [1:0] line_s2;
        logic [7:0] err;
        logic pkt_dis;
        logic bus_rst;
        logic host_en;
        logic resume;
        logic ppb_rst;
        logic usb_en;
        logic tok_busy;
        logic turn_armed;
        logic [4:0] turn_cnt;
        logic [6:0] eop_cnt;
        logic [OCC_W-1:0] occ;
        logic xfer_rdy;
        logic dp;
        logic dm;
        logic oe_n;
    } sie_st_t;

    sie_st_t st_r;
    sie_st_t st_nxt;

    logic fifo_full;
    logic fifo_empty;
    logic fifo_push;
    logic fifo_pop;
    logic [5:0] fifo_head;
    xfer_stat_t head;

    logic acc;
    logic wr;
    logic hit_err;
    logic hit_stat;
    logic hit_ctl;
    logic hit_irq;
    logic hit_tok;
    logic [7:0] wb;
    logic [7:0] ctl_rd;
    logic [7:0] stat_rd;

    ////////////////////////////////////////////////////////////////////////
    // status fifo

    assign fifo_push = sie_evt.xfer_done & ~fifo_full;

    usb_stat_fifo #(
        .WIDTH(6),
        .DEPTH(FIFO_DEPTH)
    ) u_stat_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .push(fifo_push),
        .din(sie_evt.stat),
        .pop(fifo_pop),
        .head(fifo_head),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    assign head = fifo_head;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    // access phase acknowledged at the edge where pready is seen high
    assign acc = apb_req.psel & apb_req.penable & st_r.rsp.pready;
    assign wr = acc & apb_req.pwrite;
    assign wb = apb_req.pwdata[7:0];
    assign hit_err = (apb_req.paddr == `OFS_ERROR_FLAGS);
    assign hit_stat = (apb_req.paddr == `OFS_XFER_STATUS);
    assign hit_ctl = (apb_req.paddr == `OFS_CONTROL);
    assign hit_irq = (apb_req.paddr == `OFS_IRQ_FLAGS);
    assign hit_tok = (apb_req.paddr == `OFS_TOKEN_CMD);

    // completion flag clear pops the fifo
    assign fifo_pop = wr & hit_irq & wb[`IF_XFER_DONE_BIT] & ~fifo_empty;

    // status word: endpoint, direction, bank
    always_comb begin
        stat_rd = '0;
        stat_rd[`ST_EP_LSB +: 4] = head.ep;
        stat_rd[`ST_DIR_BIT] = head.dir;
        stat_rd[`ST_ODD_BIT] = head.odd;
    end

    // control word with live line state and mode-shared bit 5
    always_comb begin
        ctl_rd = '0;
        ctl_rd[`CT_JSTATE_BIT] = (st_r.line_s2 == 2'h2);
        ctl_rd[`CT_SE0_BIT] = (st_r.line_s2 == 2'h0);
        ctl_rd[`CT_PACKET_PROCESSING_DISABLE_BIT] = st_r.host_en ? st_r.tok_busy : st_r.pkt_dis;
        ctl_rd[`CT_BUSRST_BIT] = st_r.bus_rst;
        ctl_rd[`CT_HOST_CAPABILITY_ENABLE_BIT] = st_r.host_en;
        ctl_rd[`CT_RESUME_BIT] = st_r.resume;
        ctl_rd[`CT_PPBRST_BIT] = st_r.ppb_rst;
        ctl_rd[`CT_USBEN_BIT] = st_r.usb_en;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;

        // line pins through two flops
        // only the second stage is read, the first may still be settling
        st_nxt.line_s1 = {usb_dp_in, usb_dm_in};
        st_nxt.line_s2 = st_r.line_s1;

        // apb answer: one wait state, then pready for one cycle
        // read data is latched with pready so it stands at the edge the master samples
        st_nxt.rsp.pready = 1'b0;
        st_nxt.rsp.pslverr = 1'b0;
        st_nxt.rsp.prdata = '0;
        if (apb_req.psel && apb_req.penable && !st_r.rsp.pready) begin
            st_nxt.rsp.pready = 1'b1;
            if (hit_err) begin
                st_nxt.rsp.prdata = {24'h000000, st_r.err};
            end else if (hit_stat) begin
                st_nxt.rsp.prdata = {24'h000000, stat_rd};
            end else if (hit_ctl) begin
                st_nxt.rsp.prdata = {24'h000000, ctl_rd};
            end else if (hit_irq) begin
                st_nxt.rsp.prdata = 32'h00000000;
                st_nxt.rsp.prdata[`IF_XFER_DONE_BIT] = ~fifo_empty;
            end else if (hit_tok) begin
                st_nxt.rsp.prdata = {24'h000000, st_r.ctl.tok_cmd};
            end else begin
                st_nxt.rsp.pslverr = 1'b1;
            end
        end

        // pulses default low
        st_nxt.ctl.tok_start = 1'b0;
        st_nxt.ctl.tok_reject = 1'b0;
        st_nxt.ctl.host_rst = 1'b0;

        // error flags: write one to clear, hardware set wins
        // a new event in the clearing cycle survives, so no error is lost
        if (wr && hit_err) begin
            st_nxt.err = st_r.err & ~wb;
        end
        if (!st_r.host_en && sie_evt.tok_crc_bad) begin
            st_nxt.err[`EF_CRC_EOF_BIT] = 1'b1;
            st_nxt.ctl.tok_reject = 1'b1;
        end
        // end of frame error in host mode
        if (st_r.host_en && sie_evt.sof_zero && sie_evt.link_busy) begin
            st_nxt.err[`EF_CRC_EOF_BIT] = 1'b1;
        end
        if (sie_evt.pid_bad) begin
            st_nxt.err[`EF_PID_BIT] = 1'b1;
        end
        if (sie_evt.dma_late || sie_evt.rx_trunc) begin
            st_nxt.err[`EF_DMA_BIT] = 1'b1;
        end

        // bus turnaround idle count after eop
        // each eop restarts the count, so one late reply cannot leak into the next
        if (sie_evt.eop) begin
            st_nxt.turn_armed = sie_evt.await_resp;
            st_nxt.turn_cnt = '0;
        end else if (st_r.turn_armed) begin
            if (sie_evt.rx_start) begin
                st_nxt.turn_armed = 1'b0;
            end else if (sie_evt.bit_tick) begin
                if (st_r.turn_cnt == 5'(TURN_BITS)) begin
                    st_nxt.err[`EF_TURN_BIT] = 1'b1;
                    st_nxt.turn_armed = 1'b0;
                end else begin
                    st_nxt.turn_cnt = st_r.turn_cnt + 5'h01;
                end
            end
        end

        // control register write
        // bit 5 reads as token busy in host mode, so it is only stored in device mode
        if (wr && hit_ctl) begin
            st_nxt.bus_rst = wb[`CT_BUSRST_BIT];
            st_nxt.host_en = wb[`CT_HOST_CAPABILITY_ENABLE_BIT];
            st_nxt.resume = wb[`CT_RESUME_BIT];
            st_nxt.ppb_rst = wb[`CT_PPBRST_BIT];
            st_nxt.usb_en = wb[`CT_USBEN_BIT];
            if (!st_r.host_en) begin
                st_nxt.pkt_dis = wb[`CT_PACKET_PROCESSING_DISABLE_BIT];
            end
        end
        // setup token halts processing, set wins over clear
        if (!st_r.host_en && sie_evt.setup_tok) begin
            st_nxt.pkt_dis = 1'b1;
        end

        // token completion frees the token port
        if (sie_evt.tok_done) begin
            st_nxt.tok_busy = 1'b0;
        end
        // token command starts a host token
        if (wr && hit_tok && st_r.host_en && !st_r.tok_busy) begin
            st_nxt.ctl.tok_cmd = wb;
            st_nxt.ctl.tok_start = 1'b1;
            st_nxt.tok_busy = 1'b1;
        end

        // low-speed eop after resume ends in host mode
        // the counter keeps se0 on the line after the resume bit itself is gone
        if (st_r.eop_cnt != '0) begin
            st_nxt.eop_cnt = st_r.eop_cnt - 7'h01;
        end
        if (st_r.host_en && st_r.resume && !st_nxt.resume) begin
            st_nxt.eop_cnt = 7'(`LS_EOP_CYC);
        end

        // any host enable change resets host logic
        // a toggle drops any token in flight so the engine restarts clean
        if (st_nxt.host_en != st_r.host_en) begin
            st_nxt.ctl.host_rst = 1'b1;
            st_nxt.tok_busy = 1'b0;
            st_nxt.ctl.tok_start = 1'b0;
            st_nxt.eop_cnt = '0;
            st_nxt.turn_armed = 1'b0;
        end

        st_nxt.ctl.host_en = st_nxt.host_en;
        st_nxt.ctl.proc_en = st_nxt.usb_en & ~(st_nxt.pkt_dis & ~st_nxt.host_en);

        // occupancy mirror so the ready output comes straight from a flop
        if (fifo_push && !fifo_pop) begin
            st_nxt.occ = st_r.occ + 1'b1;
        end else if (fifo_pop && !fifo_push) begin
            st_nxt.occ = st_r.occ - 1'b1;
        end
        st_nxt.xfer_rdy = (st_nxt.occ != OCC_W'(FIFO_DEPTH));

        // line drive: bus reset, then resume k, then eop se0
        st_nxt.oe_n = 1'b1;
        st_nxt.dp = 1'b0;
        st_nxt.dm = 1'b0;
        if (st_nxt.host_en && st_nxt.bus_rst) begin
            st_nxt.oe_n = 1'b0;
        end else if (st_nxt.resume) begin
            st_nxt.oe_n = 1'b0;
            st_nxt.dm = 1'b1;
        end else if (st_nxt.eop_cnt != '0) begin
            st_nxt.oe_n = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '{
                err: `EF_RESET,
                oe_n: 1'b1,
                xfer_rdy: 1'b1,
                line_s1: 2'h2,
                line_s2: 2'h2,
                default: '0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign apb_rsp = st_r.rsp;
    assign sie_ctl = st_r.ctl;
    // engine may finish a transaction while an entry is free
    assign xfer_ready = st_r.xfer_rdy;
    assign usb_dp_out = st_r.dp;
    assign usb_dm_out = st_r.dm;
    assign usb_oe_n = st_r.oe_n;
endmodule

// ### tb/usb_sie_properties.sv
/* port checker for the usb status and control block.
   assumes it is bound to usb_sie_status_control. */
`timescale 1ns/1ps

module usb_sie_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire usb_sie_pkg::apb_req_t apb_req,
    input wire usb_sie_pkg::apb_rsp_t apb_rsp,
    input wire usb_sie_pkg::sie_evt_t sie_evt,
    input wire logic xfer_ready,
    input wire usb_sie_pkg::sie_ctl_t sie_ctl,
    input wire logic usb_dp_out,
    input wire logic usb_dm_out,
    input wire logic usb_oe_n
);
    import usb_sie_pkg::*;
    logic wr;
    logic wc;
    logic pop;
    logic se0;
    // finished writes, control writes, queue pops, driven se0
    assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    assign wc = wr && apb_req.paddr == 8'h08;
    assign pop = wr && apb_req.paddr == 8'h0c && apb_req.pwdata[3];
    assign se0 = !usb_oe_n && !usb_dp_out && !usb_dm_out;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////
    crc_reject_a: assert property (
        sie_evt.tok_crc_bad && !sie_ctl.host_en |=> sie_ctl.tok_reject)
        else $error("bad token not rejected");
    setup_halt_a: assert property (
        sie_evt.setup_tok && !sie_ctl.host_en |=> !sie_ctl.proc_en)
        else $error("setup did not halt processing");
    token_host_a: assert property (
        sie_ctl.tok_start |-> sie_ctl.host_en)
        else $error("token started outside host mode");
    host_reset_a: assert property (
        $changed(sie_ctl.host_en) |-> ##[0:1] sie_ctl.host_rst)
        else $error("host enable change without host reset");
    full_hold_a: assert property (
        !xfer_ready && !pop |=> !xfer_ready)
        else $error("full queue freed without a pop");
    ready_pop_a: assert property (
        $rose(xfer_ready) |-> $past(pop) || $past(pop, 2))
        else $error("queue space appeared without a pop");
    bus_reset_a: assert property (
        wc && apb_req.pwdata[4] && apb_req.pwdata[3] |-> ##[1:2] se0)
        else $error("bus reset not driven");
    eop_tail_a: assert property (
        wc && !apb_req.pwdata[2] && apb_req.pwdata[3] && !apb_req.pwdata[4]
        && sie_ctl.host_en && !usb_oe_n && usb_dm_out |-> ##[1:2] se0)
        else $error("resume end without eop");
endmodule

bind usb_sie_status_control usb_sie_chk chk_u (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .sie_evt(sie_evt),
    .xfer_ready(xfer_ready),
    .sie_ctl(sie_ctl),
    .usb_dp_out(usb_dp_out),
    .usb_dm_out(usb_dm_out),
    .usb_oe_n(usb_oe_n)
);

// ### tb/usb_line_model.sv
/* far side of the usb line: idle j, se0 or k as the bench selects.
   assumes the block's drive wins whenever its enable is low. */
`timescale 1ns/1ps

module usb_line_model (
    input wire logic [1:0] line_sel,
    input wire logic dp_out,
    input wire logic dm_out,
    input wire logic oe_n,
    output logic dp_in,
    output logic dm_in
);
    // wired level seen by the receiver; 0 j, 1 se0, 2 k
    always_comb begin
        if (oe_n == 1'b0) begin
            dp_in = dp_out;
            dm_in = dm_out;
        end else begin
            dp_in = (line_sel == 2'd0);
            dm_in = (line_sel == 2'd2);
        end
    end
endmodule

// ### tb/testbench.sv
/* self-checking bench for the usb status and control block.
   assumes the line model and the bound port checker. */
`timescale 1ns/1ps
`include "usb_sie_defines.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, e); end end

module testbench;
    import usb_sie_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    sie_evt_t evt = '0;
    sie_ctl_t ctl;
    logic xfer_ready, dp_in, dm_in, dp_out, dm_out, oe_n, err;
    logic [1:0] line_sel = 2'd0;
    logic [31:0] r;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    int run = 0;
    int se0_last = 0;
    // event bit index: pid 17, crc 18, dma 16, trunc 15
    int ix[4] = '{17, 18, 16, 15};
    logic [31:0] ex[4] = '{32'h1, 32'h2, 32'h20, 32'h20};
    logic [5:0] st[5] = '{6'h00, 6'h3e, 6'h15, 6'h2a, 6'h3f};

    usb_sie_status_control dut_u (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .apb_req(req),
        .apb_rsp(rsp),
        .sie_evt(evt),
        .xfer_ready(xfer_ready),
        .sie_ctl(ctl),
        .usb_dp_in(dp_in),
        .usb_dm_in(dm_in),
        .usb_dp_out(dp_out),
        .usb_dm_out(dm_out),
        .usb_oe_n(oe_n)
    );
    usb_line_model line_u (
        .line_sel(line_sel),
        .dp_out(dp_out),
        .dm_out(dm_out),
        .oe_n(oe_n),
        .dp_in(dp_in),
        .dm_in(dm_in)
    );

    initial forever #10 sys_clk = ~sys_clk;

    // timeout and length of the last driven se0 run
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (!oe_n && !dp_out && !dm_out) begin
            run <= run + 1;
        end else begin
            if (run != 0) se0_last <= run;
            run <= 0;
        end
        if (cyc == 20000) begin
            n_mismatch++;
            final_report();
        end
    end

    ////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        err = rsp.pslverr;
        req <= '{1'b0, 1'b0, w, a, d};
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(r, e)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // one-cycle engine event
    task automatic pulse(input int i);
        @(posedge sys_clk);
        evt <= sie_evt_t'(evt | (19'd1 << i));
        @(posedge sys_clk);
        evt <= sie_evt_t'(evt & ~(19'd1 << i));
    endtask

    // offer one status entry until the queue takes it
    task automatic push(input logic [5:0] s);
        @(posedge sys_clk);
        evt.stat <= s;
        evt.xfer_done <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (xfer_ready !== 1'b1);
        evt.xfer_done <= 1'b0;
    endtask

    task automatic final_report();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(8'h08, 32'h80);
        line_sel <= 2'd1;
        rd(8'h08, 32'h40);
        line_sel <= 2'd0;
        for (int i = 0; i < 4; i++) begin
            pulse(ix[i]);
            rd(8'h00, ex[i]);
            wr(8'h00, ex[i]);
        end
        evt.await_resp <= 1'b1;
        pulse(12);
        repeat (16) pulse(9);
        rd(8'h00, 32'h0);
        pulse(9);
        rd(8'h00, 32'h10);
        evt.await_resp <= 1'b0;
        wr(8'h00, 32'h10);
        for (int i = 0; i < 4; i++) push(st[i]);
        repeat (2) @(posedge sys_clk);
        `CHK(xfer_ready, 1'b0)
        rd(8'h0c, 32'h8);
        fork
            push(st[4]);
            begin
                rd(8'h04, {24'h0, st[0], 2'b00});
                wr(8'h0c, 32'h8);
            end
        join
        for (int i = 1; i < 5; i++) begin
            rd(8'h04, {24'h0, st[i], 2'b00});
            wr(8'h0c, 32'h8);
        end
        rd(8'h0c, 32'h0);
        wr(8'h08, 32'h01);
        pulse(8);
        rd(8'h08, 32'ha1);
        wr(8'h08, 32'h01);
        rd(8'h08, 32'h81);
        wr(8'h08, 32'h08);
        evt.link_busy <= 1'b1;
        @(posedge sys_clk);
        `CHK(ctl.host_en, 1'b1)
        pulse(14);
        @(posedge sys_clk);
        evt.link_busy <= 1'b0;
        rd(8'h00, 32'h2);
        wr(8'h00, 32'h2);
        wr(8'h10, 32'h69);
        wr(8'h10, 32'h55); // refused while the token is busy
        rd(8'h08, 32'ha8);
        `CHK(ctl.tok_cmd, 8'h69)
        pulse(7);
        rd(8'h08, 32'h88);
        wr(8'h08, 32'h18);
        rd(8'h08, 32'h58);
        wr(8'h08, 32'h0c); // held short here, software keeps the real hold time
        rd(8'h08, 32'h0c);
        wr(8'h08, 32'h08);
        repeat (100) @(posedge sys_clk);
        `CHK(se0_last, `LS_EOP_CYC)
        wr(8'h08, 32'h00);
        @(posedge sys_clk);
        `CHK(ctl.host_en, 1'b0)
        apb(1'b0, 8'h20, 32'h0);
        `CHK(err, 1'b1)
        `CHK(r, 32'h0)
        final_report();
    end
endmodule
